// file: cfg_bank_regs.vh
// Register offsets, field positions and reset values of the OAM and forwarding config bank.
// Included by the bank module; definitions only.
`ifndef CFG_BANK_REGS_VH
`define CFG_BANK_REGS_VH

`define ADDR_W              6
`define OFS_PORT1_VLAN_DEF  6'h2b
`define OFS_PORT1_VLAN_MASK 6'h2c
`define OFS_RULE_LOW_A      6'h2d
`define OFS_RULE_HIGH_A     6'h2e
`define OFS_RULE_LOW_B      6'h2f
`define OFS_RULE_HIGH_B     6'h30
`define OFS_RULE_LOW_C      6'h31
`define OFS_RULE_HIGH_C     6'h32
`define OFS_RULE_LOW_D      6'h33
`define OFS_RULE_HIGH_LAST  6'h34
`define OFS_OAM_BEHAVIOUR   6'h35
`define OFS_OAM_REMOTE      6'h36
`define OFS_VENDOR_LOW      6'h37
`define OFS_MODEL_VENDOR    6'h38
`define OFS_MODEL_HIGH      6'h39
`define OFS_FWD_SCHEME      6'h3a
`define OFS_FWD_SPARE       6'h3e

`define RST_PORT1_VLAN_DEF  16'h0001
`define RST_PORT1_VLAN_MASK 16'h0000
`define RST_RULE_LOW        16'hf000
`define RST_RULE_HIGH       16'h00ff
`define RST_OAM_BEHAVIOUR   16'h0380
`define RST_OAM_REMOTE      16'hfeff
`define RST_ZERO            16'h0000
`define RST_FWD_SCHEME      16'h6000
`define FWD_RSVD_HIGH       12'h600

`define VLAN_DEF_WMASK      16'hfc00
`define RULE_HIGH_WMASK     16'h0fff
`define FWD_SCHEME_WMASK    16'h000d

`define FWD_STORE           2'h0
`define FWD_MODIFIED_CUT    2'h1
`define FWD_RESERVED        2'h2
`define FWD_MII_CUT         2'h3

`define SECOND_CYCLES       32'd20000000
`define REPEAT_GAP_CYCLES   32'd1000

`endif

// file: oam_forwarding_config_bank.v
// OAM, tag-rule, port 1 VLAN and forwarding configuration bank with its small OAM sequencers.
// Assumes a word-wide register port from the EEPROM loader or management micro, all
// inputs synchronous to mclk, and event inputs given as one-cycle pulses.
`timescale 1ns/1ps
`include "cfg_bank_regs.vh"

module oam_forwarding_config_bank #(
  parameter SECOND_CYCLES     = `SECOND_CYCLES,     // cycles in one second at 20 MHz
  parameter REPEAT_GAP_CYCLES = `REPEAT_GAP_CYCLES  // spacing between repeated status frames
) (
  input  wire        mclk,                   // system clock, 20 MHz
  input  wire        rst,                    // asynchronous reset, active high
  input  wire        cfg_write,              // one-cycle write strobe
  input  wire        cfg_read,               // one-cycle read strobe
  input  wire [5:0]  cfg_addr,               // word address
  input  wire [15:0] cfg_wdata,              // write data
  output reg  [15:0] cfg_rdata,              // read data, one cycle after cfg_read
  output reg         cfg_rvalid,             // read data valid pulse
  input  wire        power_up_event,         // power-up or port 1 link-up pulse
  input  wire        power_recovery_level,   // raw power recovery status
  input  wire        state_change,           // OAM state change pulse
  input  wire        notify_request,         // status notification request frame pulse
  input  wire        status_frame_done,      // OAM sender finished a status frame
  input  wire        eeprom_load_fail,       // EEPROM load failure level
  input  wire        current_speed_100,      // current copper speed is 100M
  input  wire        copper_link_up,         // copper link state
  input  wire        copper_autoneg,         // copper autonegotiation enabled
  input  wire [3:0]  dip_status,             // DIP-switch speed/duplex report
  input  wire [3:0]  phy_status,             // PHY speed/duplex report
  input  wire        auto_fast_request,      // switch core asks for a faster scheme
  input  wire [15:0] rx_control_field,       // received OAM control field
  output reg         status_frame_req,       // ask OAM sender for a status frame
  output reg         oam_suppressed,         // OAM held off after power-up
  output reg         power_recovery_valid,   // power recovery qualified
  output reg         converter_fault_alarm,  // converter fault alarm
  output reg  [1:0]  forwarding_scheme,      // active forwarding scheme
  output reg         office_side_select,     // 1 central office, 0 customer premises
  output reg         loopback_use_100,       // loopback exercises the 100M PHY
  output reg         remote_start_hit,       // received frame is a valid remote start
  output reg         remote_end_hit,         // received frame is a valid remote end
  output reg  [3:0]  oam_status_bits,        // S7..S9 field value, bit 3 marks shown
  output reg  [47:0] oam_m_field,            // M field for outgoing OAM frames
  output reg  [15:0] port1_tag_defaults,     // priority, CFI, VLAN id in tag layout
  output reg  [15:0] port1_vlan_mask_out     // port 1 VLAN mask
);

  localparam [3:0] FIXED_10M_HALF = 4'h8;

  // Status frame sequencer states
  localparam ST_IDLE = 2'h0;
  localparam ST_REQ  = 2'h1;
  localparam ST_GAP  = 2'h2;

  reg [15:0] port1_vlan_defaults;
  reg [15:0] port1_vlan_mask;
  // Rule words a..d; the last high word also carries loopback and recovery timer bits
  reg [15:0] rule_low [0:3];
  reg [15:0] rule_high [0:3];
  reg [15:0] oam_behaviour_config;
  reg [15:0] oam_remote_function_codes;
  reg [15:0] oam_vendor_code_low;
  reg [15:0] oam_model_vendor_mix;
  reg [15:0] oam_model_code_high;
  reg [15:0] forwarding_scheme_config;

  reg [31:0] sec_div;
  reg        sec_tick;
  reg [3:0]  suppress_secs;
  reg [3:0]  recovery_secs;
  reg [1:0]  notify_state;
  reg [1:0]  frames_left;
  reg [31:0] gap_count;
  reg [15:0] next_rdata;
  integer    i;

  // Seconds code 0..7 mapped onto 0..8 s; the top code stretches to 8 s.
  function [3:0] code_seconds;
    input [2:0] code;
    begin
      code_seconds = (code == 3'h7) ? 4'h8 : {1'b0, code};
    end
  endfunction

  // Remote frame test shared by start and end: nibble, direction, function byte
  function remote_match;
    input [15:0] field;
    input [15:0] cfg;
    input [7:0]  code;
    reg          dir_ok;
    begin
      dir_ok       = cfg[11] || (field[1] == cfg[0]);
      remote_match = !cfg[6]
                     && (field[7:4] == cfg[15:12])
                     && dir_ok
                     && (field[15:8] == code);
    end
  endfunction

  function [15:0] merge_masked;
    input [15:0] old_val;
    input [15:0] new_val;
    input [15:0] wmask;
    begin
      merge_masked = (new_val & wmask) | (old_val & ~wmask);
    end
  endfunction

  // Masked merges keep read-only fields at reset whatever the writer sends
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      port1_vlan_defaults       <= `RST_PORT1_VLAN_DEF;
      port1_vlan_mask           <= `RST_PORT1_VLAN_MASK;
      for (i = 0; i < 4; i = i + 1) begin
        rule_low[i]  <= `RST_RULE_LOW;
        rule_high[i] <= `RST_RULE_HIGH;
      end
      oam_behaviour_config      <= `RST_OAM_BEHAVIOUR;
      oam_remote_function_codes <= `RST_OAM_REMOTE;
      oam_vendor_code_low       <= `RST_ZERO;
      oam_model_vendor_mix      <= `RST_ZERO;
      oam_model_code_high       <= `RST_ZERO;
      forwarding_scheme_config  <= `RST_FWD_SCHEME;
    end else if (cfg_write) begin
      case (cfg_addr)
        `OFS_PORT1_VLAN_DEF:  port1_vlan_defaults <= merge_masked(port1_vlan_defaults,
                                cfg_wdata, `VLAN_DEF_WMASK);
        `OFS_PORT1_VLAN_MASK: port1_vlan_mask <= cfg_wdata;
        `OFS_RULE_LOW_A:      rule_low[0] <= cfg_wdata;
        `OFS_RULE_LOW_B:      rule_low[1] <= cfg_wdata;
        `OFS_RULE_LOW_C:      rule_low[2] <= cfg_wdata;
        `OFS_RULE_LOW_D:      rule_low[3] <= cfg_wdata;
        `OFS_RULE_HIGH_A:     rule_high[0] <= merge_masked(rule_high[0],
                                cfg_wdata, `RULE_HIGH_WMASK);
        `OFS_RULE_HIGH_B:     rule_high[1] <= merge_masked(rule_high[1],
                                cfg_wdata, `RULE_HIGH_WMASK);
        `OFS_RULE_HIGH_C:     rule_high[2] <= merge_masked(rule_high[2],
                                cfg_wdata, `RULE_HIGH_WMASK);
        `OFS_RULE_HIGH_LAST:  rule_high[3] <= cfg_wdata;
        `OFS_OAM_BEHAVIOUR:   oam_behaviour_config <= cfg_wdata;
        `OFS_OAM_REMOTE:      oam_remote_function_codes <= cfg_wdata;
        `OFS_VENDOR_LOW:      oam_vendor_code_low <= cfg_wdata;
        `OFS_MODEL_VENDOR:    oam_model_vendor_mix <= cfg_wdata;
        `OFS_MODEL_HIGH:      oam_model_code_high <= cfg_wdata;
        `OFS_FWD_SCHEME: begin
          // The reserved scheme code is refused and the old scheme kept
          if (cfg_wdata[3:2] == `FWD_RESERVED)
            forwarding_scheme_config <= merge_masked(forwarding_scheme_config,
                                          cfg_wdata, 16'h0001);
          else
            forwarding_scheme_config <= merge_masked(forwarding_scheme_config,
                                          cfg_wdata, `FWD_SCHEME_WMASK);
        end
        default: ;
      endcase
    end
  end

  // Reads are registered so the bus answer never glitches with config writes
  always @* begin
    case (cfg_addr)
      `OFS_PORT1_VLAN_DEF:  next_rdata = port1_vlan_defaults;
      `OFS_PORT1_VLAN_MASK: next_rdata = port1_vlan_mask;
      `OFS_RULE_LOW_A:      next_rdata = rule_low[0];
      `OFS_RULE_HIGH_A:     next_rdata = rule_high[0];
      `OFS_RULE_LOW_B:      next_rdata = rule_low[1];
      `OFS_RULE_HIGH_B:     next_rdata = rule_high[1];
      `OFS_RULE_LOW_C:      next_rdata = rule_low[2];
      `OFS_RULE_HIGH_C:     next_rdata = rule_high[2];
      `OFS_RULE_LOW_D:      next_rdata = rule_low[3];
      `OFS_RULE_HIGH_LAST:  next_rdata = rule_high[3];
      `OFS_OAM_BEHAVIOUR:   next_rdata = oam_behaviour_config;
      `OFS_OAM_REMOTE:      next_rdata = oam_remote_function_codes;
      `OFS_VENDOR_LOW:      next_rdata = oam_vendor_code_low;
      `OFS_MODEL_VENDOR:    next_rdata = oam_model_vendor_mix;
      `OFS_MODEL_HIGH:      next_rdata = oam_model_code_high;
      `OFS_FWD_SCHEME:      next_rdata = forwarding_scheme_config;
      `OFS_FWD_SPARE:       next_rdata = `RST_ZERO;
      // Unmapped words read zero; writes to them are dropped
      default:              next_rdata = 16'h0000;
    endcase
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg_rdata  <= 16'h0000;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_read;
      if (cfg_read)
        cfg_rdata <= next_rdata;
    end
  end

  // One free-running divider serves both timers, so a timer started at an
  // arbitrary phase may end up to one second short
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      sec_div  <= 32'd0;
      sec_tick <= 1'b0;
    end else if (sec_div >= SECOND_CYCLES - 1) begin
      sec_div  <= 32'd0;
      sec_tick <= 1'b1;
    end else begin
      sec_div  <= sec_div + 32'd1;
      sec_tick <= 1'b0;
    end
  end

  // Power-up suppression counts divider second ticks after the event
  // A repeated event reloads the count, so a bouncing link stretches the hold-off
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      suppress_secs  <= 4'h0;
      oam_suppressed <= 1'b0;
    end else if (power_up_event) begin
      suppress_secs  <= code_seconds(oam_behaviour_config[10:8]);
      oam_suppressed <= (oam_behaviour_config[10:8] != 3'h0);
    end else if (sec_tick && suppress_secs != 4'h0) begin
      suppress_secs  <= suppress_secs - 4'h1;
      oam_suppressed <= (suppress_secs != 4'h1);
    end
  end

  // Recovery must hold through the programmed seconds; any drop restarts it
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      recovery_secs        <= 4'h0;
      power_recovery_valid <= 1'b0;
    end else if (!power_recovery_level) begin
      recovery_secs        <= code_seconds(rule_high[3][14:12]);
      power_recovery_valid <= 1'b0;
    end else if (recovery_secs == 4'h0) begin
      power_recovery_valid <= 1'b1;
    end else if (sec_tick) begin
      recovery_secs <= recovery_secs - 4'h1;
    end
  end

  // Status frame sequencer; a new event during a burst restarts the count
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      notify_state     <= ST_IDLE;
      frames_left      <= 2'h0;
      gap_count        <= 32'd0;
      status_frame_req <= 1'b0;
    end else if ((state_change || notify_request) && !oam_suppressed) begin
      frames_left      <= oam_behaviour_config[1] ? 2'h3 : 2'h1;
      notify_state     <= ST_REQ;
      status_frame_req <= 1'b1;
    end else begin
      case (notify_state)
        ST_IDLE: status_frame_req <= 1'b0;
        ST_REQ: begin
          if (status_frame_done) begin
            status_frame_req <= 1'b0;
            gap_count        <= 32'd0;
            frames_left      <= frames_left - 2'h1;
            notify_state     <= (frames_left == 2'h1) ? ST_IDLE : ST_GAP;
          end
        end
        ST_GAP: begin
          if (gap_count >= REPEAT_GAP_CYCLES - 1) begin
            status_frame_req <= 1'b1;
            notify_state     <= ST_REQ;
          end else begin
            gap_count <= gap_count + 32'd1;
          end
        end
        default: begin
          notify_state     <= ST_IDLE;
          status_frame_req <= 1'b0;
        end
      endcase
    end
  end

  // Derived outputs lag the config words by one cycle so every port is a flop
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      converter_fault_alarm <= 1'b0;
      forwarding_scheme     <= `FWD_STORE;
      office_side_select    <= 1'b0;
      loopback_use_100      <= 1'b0;
      remote_start_hit      <= 1'b0;
      remote_end_hit        <= 1'b0;
      oam_status_bits       <= 4'h0;
      oam_m_field           <= 48'h0;
      port1_tag_defaults    <= 16'h0000;
      port1_vlan_mask_out   <= 16'h0000;
    end else begin
      converter_fault_alarm <= eeprom_load_fail & ~oam_behaviour_config[2];
      // Auto mode steps to MII cut-through only while the core asks for it
      if (forwarding_scheme_config[0] && auto_fast_request)
        forwarding_scheme <= `FWD_MII_CUT;
      else
        forwarding_scheme <= forwarding_scheme_config[3:2];
      office_side_select <= oam_behaviour_config[0];
      loopback_use_100   <= rule_high[3][15] | current_speed_100;
      // Start needs its own enable on top of the shared frame match
      remote_start_hit <= oam_behaviour_config[5]
                          && remote_match(rx_control_field, oam_behaviour_config,
                                          oam_remote_function_codes[7:0]);
      remote_end_hit   <= remote_match(rx_control_field, oam_behaviour_config,
                                       oam_remote_function_codes[15:8]);
      if (copper_link_up)
        oam_status_bits <= oam_behaviour_config[4] ? 4'h0 : {1'b1, phy_status[2:0]};
      else if (copper_autoneg)
        oam_status_bits <= oam_behaviour_config[3] ? FIXED_10M_HALF : dip_status;
      else
        oam_status_bits <= dip_status;
      oam_m_field <= {oam_model_code_high, oam_model_vendor_mix,
                      oam_vendor_code_low};
      port1_tag_defaults  <= port1_vlan_defaults;
      port1_vlan_mask_out <= port1_vlan_mask;
    end
  end

endmodule

// file: cfg_host_model.sv
// Register-port host model standing in for the loader or management micro.
// Assumes mclk and a design that answers a read one cycle after the strobe.
`timescale 1ns/1ps
module cfg_host_model (
  input  wire        mclk,       // system clock
  input  wire [15:0] cfg_rdata,  // read data
  input  wire        cfg_rvalid, // read answer
  output reg         cfg_write,  // write strobe
  output reg         cfg_read,   // read strobe
  output reg  [5:0]  cfg_addr,   // word address
  output reg  [15:0] cfg_wdata   // write data
);
  initial begin
    cfg_write = 1'b0;
    cfg_read  = 1'b0;
    cfg_addr  = 6'h00;
    cfg_wdata = 16'h0000;
  end
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge mclk) #1;
    cfg_write = 1'b1;
    cfg_addr  = a;
    cfg_wdata = d;
    @(posedge mclk) #1;
    cfg_write = 1'b0;
    // Stale data would hide a design that samples the bus late
    cfg_wdata = ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    int i;
    @(posedge mclk) #1;
    cfg_read = 1'b1;
    cfg_addr = a;
    @(posedge mclk) #1;
    cfg_read = 1'b0;
    for (i = 0; i < 4 && cfg_rvalid !== 1'b1; i++) @(posedge mclk) #1;
    d = cfg_rdata;
  endtask
endmodule

// file: cfg_bank_sva.sv
// Port checker for the config bank, bound to its top module.
// Assumes one mclk domain and rst active high asynchronous.
`timescale 1ns/1ps
module cfg_bank_sva (
  input wire logic        mclk,                  // clock
  input wire logic        rst,                   // reset
  input wire logic        cfg_write,             // write strobe
  input wire logic        cfg_read,              // read strobe
  input wire logic [15:0] cfg_rdata,             // read data
  input wire logic        cfg_rvalid,            // read answer
  input wire logic        state_change,          // event
  input wire logic        notify_request,        // event
  input wire logic        oam_suppressed,        // hold-off
  input wire logic        status_frame_req,      // frame request
  input wire logic        eeprom_load_fail,      // load failure
  input wire logic        converter_fault_alarm, // alarm
  input wire logic        current_speed_100,     // speed
  input wire logic        loopback_use_100,      // loopback PHY
  input wire logic        copper_link_up,        // link
  input wire logic [3:0]  phy_status,            // PHY report
  input wire logic [3:0]  oam_status_bits,       // status field
  input wire logic        power_recovery_level,  // raw recovery
  input wire logic        power_recovery_valid,  // qualified
  input wire logic [1:0]  forwarding_scheme,     // scheme
  input wire logic [47:0] oam_m_field,           // M field
  input wire logic [15:0] port1_vlan_mask_out    // VLAN mask
);
  wire [2:0] phy_low = phy_status[2:0];
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  AST_READ_ANSWER: assert property (cfg_rvalid == $past(cfg_read))
    else $error("read answer timing wrong");
  AST_RDATA_HOLD: assert property (!cfg_rvalid |-> $stable(cfg_rdata))
    else $error("read data moved without a read");
  AST_NO_RSVD_SCHEME: assert property (forwarding_scheme != 2'h2)
    else $error("reserved forwarding scheme active");
  AST_NOTIFY_START: assert property ((state_change || notify_request) && !oam_suppressed
    |=> status_frame_req)
    else $error("status frame not requested");
  AST_FAULT_CAUSE: assert property (!eeprom_load_fail [*3] |-> !converter_fault_alarm)
    else $error("alarm without load failure");
  AST_LOOPBACK_100: assert property (current_speed_100 |=> loopback_use_100)
    else $error("loopback not on 100M PHY");
  AST_STATUS_SHOWN: assert property ($past(copper_link_up) |->
    (oam_status_bits == 4'h0 || oam_status_bits == {1'b1, $past(phy_low)}))
    else $error("link-up status field wrong");
  AST_RECOVERY_DROP: assert property (!power_recovery_level [*3] |-> !power_recovery_valid)
    else $error("recovery valid without level");
  AST_CFG_OUT_STABLE: assert property (!$past(cfg_write, 2) && !$past(cfg_write)
    |-> $stable({oam_m_field, port1_vlan_mask_out}))
    else $error("config outputs moved without a write");
endmodule
bind oam_forwarding_config_bank cfg_bank_sva u_sva (
  .mclk(mclk), .rst(rst), .cfg_write(cfg_write), .cfg_read(cfg_read),
  .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .state_change(state_change),
  .notify_request(notify_request), .oam_suppressed(oam_suppressed),
  .status_frame_req(status_frame_req), .eeprom_load_fail(eeprom_load_fail),
  .converter_fault_alarm(converter_fault_alarm), .current_speed_100(current_speed_100),
  .loopback_use_100(loopback_use_100), .copper_link_up(copper_link_up),
  .phy_status(phy_status), .oam_status_bits(oam_status_bits),
  .power_recovery_level(power_recovery_level), .power_recovery_valid(power_recovery_valid),
  .forwarding_scheme(forwarding_scheme), .oam_m_field(oam_m_field),
  .port1_vlan_mask_out(port1_vlan_mask_out));

// file: oam_forwarding_config_bank_test.sv
// Self-checking bench for the OAM and forwarding config bank.
// Assumes the host model drives the register port; the OAM sender is mimicked here.
`timescale 1ns/1ps
module oam_forwarding_config_bank_test;
  typedef struct packed {logic w; logic [5:0] a; logic [15:0] d; logic [15:0] e;} row_t;
  logic        mclk, rst, cfg_write, cfg_read, cfg_rvalid, power_up_event, state_change;
  logic        power_recovery_level, notify_request, status_frame_done, eeprom_load_fail;
  logic        current_speed_100, copper_link_up, copper_autoneg, auto_fast_request;
  logic        status_frame_req, oam_suppressed, power_recovery_valid, converter_fault_alarm;
  logic        office_side_select, loopback_use_100, remote_start_hit, remote_end_hit;
  logic [5:0]  cfg_addr;
  logic [15:0] cfg_wdata, cfg_rdata, rx_control_field, port1_tag_defaults;
  logic [15:0] port1_vlan_mask_out, got;
  logic [3:0]  dip_status, phy_status, oam_status_bits;
  logic [1:0]  forwarding_scheme;
  logic [47:0] oam_m_field;
  int          fails, n_tests, cyc, frames, i;
  // Reset reads first, then writes with their read-back
  row_t rows [0:30] = '{
    {1'b0,6'h2b,16'h0,16'h0001}, {1'b0,6'h2c,16'h0,16'h0000}, {1'b0,6'h2d,16'h0,16'hf000},
    {1'b0,6'h2e,16'h0,16'h00ff}, {1'b0,6'h2f,16'h0,16'hf000}, {1'b0,6'h30,16'h0,16'h00ff},
    {1'b0,6'h31,16'h0,16'hf000}, {1'b0,6'h32,16'h0,16'h00ff}, {1'b0,6'h33,16'h0,16'hf000},
    {1'b0,6'h34,16'h0,16'h00ff}, {1'b0,6'h35,16'h0,16'h0380}, {1'b0,6'h36,16'h0,16'hfeff},
    {1'b0,6'h37,16'h0,16'h0000}, {1'b0,6'h38,16'h0,16'h0000}, {1'b0,6'h39,16'h0,16'h0000},
    {1'b0,6'h3a,16'h0,16'h6000}, {1'b0,6'h3e,16'h0,16'h0000}, {1'b0,6'h3b,16'h0,16'h0000},
    {1'b1,6'h2b,16'hffff,16'hfc01}, {1'b1,6'h2c,16'ha5c3,16'ha5c3},
    {1'b1,6'h2d,16'h0123,16'h0123}, {1'b1,6'h2e,16'hffff,16'h0fff},
    {1'b1,6'h34,16'h0000,16'h0000}, {1'b1,6'h36,16'h1234,16'h1234},
    {1'b1,6'h37,16'h1234,16'h1234}, {1'b1,6'h38,16'h5678,16'h5678},
    {1'b1,6'h39,16'h9abc,16'h9abc}, {1'b1,6'h3a,16'hffff,16'h600d},
    {1'b1,6'h3a,16'h0008,16'h600c}, {1'b1,6'h3e,16'hffff,16'h0000},
    {1'b1,6'h3b,16'hffff,16'h0000}};
  oam_forwarding_config_bank #(.SECOND_CYCLES(20), .REPEAT_GAP_CYCLES(4)) u_dut (
    .mclk(mclk), .rst(rst), .cfg_write(cfg_write), .cfg_read(cfg_read), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .power_up_event(power_up_event), .power_recovery_level(power_recovery_level),
    .state_change(state_change), .notify_request(notify_request),
    .status_frame_done(status_frame_done), .eeprom_load_fail(eeprom_load_fail),
    .current_speed_100(current_speed_100), .copper_link_up(copper_link_up),
    .copper_autoneg(copper_autoneg), .dip_status(dip_status), .phy_status(phy_status),
    .auto_fast_request(auto_fast_request), .rx_control_field(rx_control_field),
    .status_frame_req(status_frame_req), .oam_suppressed(oam_suppressed),
    .power_recovery_valid(power_recovery_valid), .converter_fault_alarm(converter_fault_alarm),
    .forwarding_scheme(forwarding_scheme), .office_side_select(office_side_select),
    .loopback_use_100(loopback_use_100), .remote_start_hit(remote_start_hit),
    .remote_end_hit(remote_end_hit), .oam_status_bits(oam_status_bits),
    .oam_m_field(oam_m_field), .port1_tag_defaults(port1_tag_defaults),
    .port1_vlan_mask_out(port1_vlan_mask_out));
  cfg_host_model u_host (.mclk(mclk), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .cfg_write(cfg_write), .cfg_read(cfg_read), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // OAM sender: finishes each requested frame one cycle later
  always @(posedge mclk) begin
    #1 status_frame_done = status_frame_req & ~status_frame_done;
    if (status_frame_done) frames++;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      print_verdict;
    end
  end
  task automatic chk(input logic [47:0] g, input logic [47:0] e, input string what);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("FAIL %0t %s got %h exp %h", $time, what, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic set35(input logic [15:0] d);
    u_host.wr(6'h35, d);
    tick(3);
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    {rst, power_up_event, state_change, notify_request} = 4'h8;
    {power_recovery_level, eeprom_load_fail, current_speed_100, copper_link_up} = 4'h0;
    {copper_autoneg, auto_fast_request, dip_status, phy_status} = 10'h000;
    rx_control_field = 16'h0000;
    repeat (12) @(posedge mclk);
    #1 rst = 1'b0;
    for (i = 0; i < 31; i++) begin
      if (rows[i].w) u_host.wr(rows[i].a, rows[i].d);
      u_host.rd(rows[i].a, got);
      chk(got, rows[i].e, "register word");
    end
    tick(3);
    chk(oam_m_field, 48'h9abc_5678_1234, "m field");
    chk(port1_vlan_mask_out, 16'ha5c3, "vlan mask");
    chk(port1_tag_defaults, 16'hfc01, "tag defaults");
    chk(forwarding_scheme, 2'h3, "scheme kept");
    auto_fast_request = 1'b1;
    u_host.wr(6'h3a, 16'h0004);
    tick(3);
    chk(forwarding_scheme, 2'h1, "fixed scheme");
    u_host.wr(6'h3a, 16'h0001);
    tick(3);
    chk(forwarding_scheme, 2'h3, "auto scheme");
    $display("test registers done");
    chk(loopback_use_100, 1'b0, "loopback speed");
    current_speed_100 = 1'b1;
    tick(3);
    chk(loopback_use_100, 1'b1, "loopback follows speed");
    current_speed_100 = 1'b0;
    u_host.wr(6'h34, 16'ha000);
    tick(1);
    power_recovery_level = 1'b1;
    tick(10);
    chk(loopback_use_100, 1'b1, "loopback 100");
    chk(power_recovery_valid, 1'b0, "recovery early");
    tick(40);
    chk(power_recovery_valid, 1'b1, "recovery late");
    eeprom_load_fail = 1'b1;
    tick(3);
    chk(converter_fault_alarm, 1'b1, "alarm on");
    set35(16'h0204);
    chk(converter_fault_alarm, 1'b0, "alarm off");
    power_up_event = 1'b1;
    tick(1);
    power_up_event = 1'b0;
    tick(1);
    chk(oam_suppressed, 1'b1, "suppressed");
    state_change = 1'b1;
    tick(1);
    state_change = 1'b0;
    tick(3);
    chk(status_frame_req, 1'b0, "event ignored");
    for (i = 0; i < 60 && oam_suppressed === 1'b1; i++) tick(1);
    chk(i > 15 && i < 45, 1'b1, "suppress length");
    i = frames;
    state_change = 1'b1;
    tick(1);
    state_change = 1'b0;
    tick(40);
    chk(frames - i, 1, "one frame");
    set35(16'h0106);
    i = frames;
    notify_request = 1'b1;
    tick(1);
    notify_request = 1'b0;
    tick(60);
    chk(frames - i, 3, "three frames");
    $display("test oam timing done");
    u_host.wr(6'h36, 16'hfeff);
    set35(16'ha020);
    rx_control_field = 16'hffa0;
    tick(3);
    chk({remote_start_hit, remote_end_hit}, 2'h2, "start hit");
    rx_control_field = 16'hfea0;
    tick(3);
    chk({remote_start_hit, remote_end_hit}, 2'h1, "end hit");
    rx_control_field = 16'hfea2;
    tick(3);
    chk(remote_end_hit, 1'b0, "direction");
    set35(16'ha820);
    chk(remote_end_hit, 1'b1, "no direction check");
    rx_control_field = 16'hfe52;
    tick(3);
    chk(remote_end_hit, 1'b0, "nibble");
    rx_control_field = 16'hfea2;
    set35(16'ha860);
    chk(remote_end_hit, 1'b0, "remote off");
    {copper_link_up, phy_status, copper_autoneg, dip_status} = 10'h2b3;
    set35(16'h0000);
    chk(oam_status_bits, 4'hd, "shown");
    set35(16'h0010);
    chk(oam_status_bits, 4'h0, "hidden");
    copper_link_up = 1'b0;
    tick(3);
    chk(oam_status_bits, 4'h3, "dip report");
    set35(16'h0009);
    chk(oam_status_bits, 4'h8, "fixed report");
    chk(office_side_select, 1'b1, "office side");
    rst = 1'b1;
    tick(2);
    chk(office_side_select, 1'b0, "reset output");
    rst = 1'b0;
    u_host.rd(6'h35, got);
    chk(got, 16'h0380, "reset again");
    $display("test oam fields done");
    print_verdict;
  end
endmodule
